// *** hw/sofu_top.sv ***
// stack operand float unit: sequencer, datapath and register slave
//
// Chosen here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/100ps
// Behaviour
// (RQ1) add op sums A and B, result over A; low opcode bits pick pointer register
// (RQ2) subtract op computes A minus B, result over A
// (RQ3) multiply op computes A times B, result over A
// (RQ4) divide op computes A over B, quotient over A
// (RQ5) divide by zero divisor leaves every stack word untouched
// (RQ6) top bit of high word is the sign, sign-magnitude form
// (RQ7) exponent in high bits 14..7, excess 200 octal
// (RQ8) fraction is 23 stored bits plus hidden leading one
// (RQ9) first stored fraction bit is high word bit 6, low word follows
// (RQ10) results round away from zero
// (RQ11) exponent code zero means operand is zero
// (RQ12) zero result is written as two all-zero words
// (RQ13) operands read at base, +2 (B) and +4, +6 (A)
// (RQ14) result high at base+4, low at base+6
// (RQ15) pointer register becomes base plus 4 on completion
// (RQ16) success sets N and Z from result, clears V and C
// (RQ17) trap flags: overflow V; underflow V,N; divide by zero V,N,C; Z clear
// (RQ18) float traps go through vector 244 octal
// (RQ19) bus request well before completion abandons the instruction
// (RQ20) abandoned instruction restarts from its start after the interrupt
// (RQ21) host supplies register value and runs each memory transfer in turn
module sofu_top
  import sofu_pkg::*;
#(
  parameter int MEM_CYCLES_EST = 4,
  parameter int AXI_AW         = 8
) (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  srst,
  // register bus
  input  wire logic [AXI_AW-1:0]     s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [AXI_AW-1:0]     s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // instruction from the host core
  input  wire logic                  cmdValid,
  input  wire logic [15:0]           cmdOpcode,
  input  wire logic [15:0]           cmdRegValue,
  output logic                       cmdReady,
  input  wire logic                  bus_priority_request,
  // memory transfers done by the host
  output sofu_pkg::sofu_mem_t        memOut,
  input  wire logic                  memAck,
  input  wire logic [15:0]           memRdata,
  // completion report
  output sofu_pkg::sofu_done_t       doneOut
);
  import sofu_pkg::*;

  if (MEM_CYCLES_EST < 1 || MEM_CYCLES_EST > 1000 || AXI_AW < 4 || AXI_AW > 32) begin : g_bad_param
    $error("sofu_top: parameter out of range");
  end

  sofu_state_t st_ff;
  sofu_mem_t   mem_ff;
  sofu_done_t  done_ff;
  sofu_res_t   res_ff, resCalc, resDiv;
  logic        cmdReady_ff, ctrlEnable_ff, wroteOp_ff, lastTrap_ff, lastAbort_ff;
  logic [1:0]  xferIdx_ff, opSel_ff;
  logic [2:0]  regNum_ff;
  logic [15:0] base_ff, remain_ff;
  logic [31:0] aw_ff, bw_ff, lastResult_ff;
  logic [3:0]  lastCc_ff;
  logic [49:0] divQ_ff, nxt_divQ;
  logic [25:0] divRem_ff, nxt_divRem, remSub;
  logic [5:0]  divCnt_ff;
  logic        take, abortNow, divGe;

  // the operand is zero whenever its exponent code is zero
  function automatic logic [23:0] mant(input logic [31:0] w);
    mant = (w[30:23] == 8'h00) ? 24'h000000 : {1'b1, w[22:0]}; // RQ8 RQ9 RQ11
  endfunction

  function automatic logic [15:0] xferAddr(input logic [15:0] base, input logic wr, input logic [1:0] idx);
    logic [15:0] off;
    off = OFF_B_HI;
    unique case ({wr, idx})
      3'b001:  off = OFF_B_LO;
      3'b010:  off = OFF_A_HI;
      3'b011:  off = OFF_A_LO;
      3'b100:  off = OFF_A_HI;
      3'b101:  off = OFF_A_LO;
      default: off = OFF_B_HI;
    endcase
    xferAddr = base + off; // RQ13 RQ14
  endfunction

  // value of mag is mag/2^50 * 2^(ex-128); stk marks nonzero bits already lost
  function automatic sofu_res_t normRound(input logic [49:0] mag, input logic signed [11:0] ex,
                                          input logic stk, input logic sgn);
    sofu_res_t         r;
    logic [49:0]       sh;
    logic [24:0]       fr;
    logic signed [11:0] e;
    int                lz;
    r  = '0;
    lz = 0;
    for (int i = 0; i < 50; i++) begin
      if (mag[i]) begin
        lz = 49 - i;
      end
    end
    sh = mag << lz;
    e  = ex - 12'(lz);
    // any lost bit bumps the magnitude up by one unit
    fr = {1'b0, sh[49:26]} + 25'((sh[25:0] != 26'h0) || stk); // RQ10
    if (fr[24]) begin
      fr = {2'b01, 23'h0};
      e  = e + 12'sd1;
    end
    if (mag == 50'h0) begin
      r = '0; // RQ12
    end else if (e > 12'sd255) begin
      r.ovf = 1'b1;
    end else if (e < 12'sd1) begin
      r.unf = 1'b1; // RQ12
    end else begin
      r.word = {sgn, e[7:0], fr[22:0]}; // RQ6 RQ7
    end
    return r;
  endfunction

  function automatic sofu_done_t mkDone(input logic ccw, input logic [3:0] nzvc, input logic trap,
                                        input logic regw, input logic restart, input logic [2:0] rn,
                                        input logic [15:0] base);
    sofu_done_t d;
    d          = '0;
    d.valid    = 1'b1;
    d.ccWrite  = ccw;
    {d.n, d.z, d.v, d.c} = nzvc;
    d.trap     = trap;
    d.vector   = trap ? TRAP_VECTOR : 16'h0000; // RQ18
    d.regWrite = regw;
    d.regNum   = rn;
    d.regValue = base + OFF_A_HI; // RQ15
    d.restart  = restart;
    return d;
  endfunction

  // add, subtract and multiply in one combinational pass
  always_comb begin
    logic [23:0] ma, mb, mBig, mSm;
    logic [7:0]  ea, eb, eBig, eSm, d;
    logic        sa, sb, aBig;
    logic [49:0] extBig, extSm, shSm, mag;
    logic        stk;
    logic [47:0] prod;
    ma = mant(aw_ff);
    mb = mant(bw_ff);
    ea = aw_ff[30:23];
    eb = bw_ff[30:23];
    sa = aw_ff[31];
    sb = bw_ff[31] ^ (opSel_ff == OP_SUB); // RQ2
    aBig = {ea, ma} >= {eb, mb};
    eBig = aBig ? ea : eb;
    eSm  = aBig ? eb : ea;
    mBig = aBig ? ma : mb;
    mSm  = aBig ? mb : ma;
    d = eBig - eSm;
    extBig = {1'b0, mBig, 25'h0};
    extSm  = {1'b0, mSm, 25'h0};
    shSm   = extSm >> d;
    stk    = (shSm << d) != extSm;
    // a truncated subtrahend is short by less than one unit, so take one more off
    mag = (sa == sb) ? extBig + shSm : extBig - shSm - 50'(stk);
    prod = ma * mb;
    if (opSel_ff == OP_MUL) begin
      resCalc = normRound({prod, 2'b00}, $signed({4'h0, ea}) + $signed({4'h0, eb}) - $signed({4'h0, EXP_BIAS}),
                          1'b0, sa ^ bw_ff[31]); // RQ3
    end else begin
      resCalc = normRound(mag, $signed({4'h0, eBig}) + 12'sd1, stk, aBig ? sa : sb); // RQ1 RQ2
    end
  end

  // one restoring division step per cycle
  always_comb begin
    divGe      = divRem_ff >= {2'b00, mant(bw_ff)};
    remSub     = divGe ? divRem_ff - {2'b00, mant(bw_ff)} : divRem_ff;
    nxt_divRem = {remSub[24:0], 1'b0};
    nxt_divQ   = {divQ_ff[48:0], divGe};
    resDiv = normRound(nxt_divQ, $signed({4'h0, aw_ff[30:23]}) - $signed({4'h0, bw_ff[30:23]})
                       + $signed({4'h0, EXP_BIAS}) + 12'sd1, remSub != 26'h0, aw_ff[31] ^ bw_ff[31]); // RQ4
  end

  assign take     = cmdValid && cmdReady_ff;
  // never abandon with a transfer outstanding, and never once writing began
  assign abortNow = bus_priority_request && !mem_ff.req && (remain_ff > 16'(ABORT_WINDOW_CYC)); // RQ19

  always_ff @(posedge clk) begin
    if (srst) begin
      cmdReady_ff <= 1'b0;
    end else begin
      cmdReady_ff <= ctrlEnable_ff && (st_ff == S_IDLE) && !take;
    end
  end

  // sequencer; the host completes each transfer before the next is raised
  always_ff @(posedge clk) begin
    if (srst) begin
      st_ff      <= S_IDLE;
      mem_ff     <= '0;
      done_ff    <= '0;
      xferIdx_ff <= 2'h0;
    end else begin
      done_ff.valid <= 1'b0;
      unique case (st_ff)
        S_IDLE: begin
          xferIdx_ff <= 2'h0;
          if (take && cmdOpcode[15:5] == OPC_FLOAT) begin
            st_ff <= S_READ;
          end else if (take) begin
            done_ff <= mkDone(1'b0, 4'h0, 1'b0, 1'b0, 1'b0, cmdOpcode[2:0], cmdRegValue);
          end
        end
        S_READ: begin
          if (abortNow) begin
            done_ff <= mkDone(1'b0, 4'h0, 1'b0, 1'b0, 1'b1, regNum_ff, base_ff); // RQ19 RQ20
            st_ff   <= S_IDLE;
          end else if (!mem_ff.req) begin
            mem_ff.req   <= 1'b1; // RQ21
            mem_ff.write <= 1'b0;
            mem_ff.addr  <= xferAddr(base_ff, 1'b0, xferIdx_ff); // RQ13
          end else if (memAck) begin
            mem_ff.req <= 1'b0;
            xferIdx_ff <= xferIdx_ff + 2'h1;
            if (xferIdx_ff == 2'h3) begin
              st_ff <= S_CALC;
            end
          end
        end
        S_CALC: begin
          xferIdx_ff <= 2'h0;
          if (abortNow) begin
            done_ff <= mkDone(1'b0, 4'h0, 1'b0, 1'b0, 1'b1, regNum_ff, base_ff); // RQ19 RQ20
            st_ff   <= S_IDLE;
          end else if (opSel_ff == OP_DIV && bw_ff[30:23] == 8'h00) begin
            done_ff <= mkDone(1'b1, CC_DIVZERO, 1'b1, 1'b0, 1'b0, regNum_ff, base_ff); // RQ5 RQ17
            st_ff   <= S_IDLE;
          end else begin
            st_ff <= (opSel_ff == OP_DIV) ? S_DIV : S_WRITE;
          end
        end
        S_DIV: begin
          if (abortNow) begin
            done_ff <= mkDone(1'b0, 4'h0, 1'b0, 1'b0, 1'b1, regNum_ff, base_ff); // RQ19 RQ20
            st_ff   <= S_IDLE;
          end else if (divCnt_ff == 6'(DIV_STEPS - 1)) begin
            st_ff <= S_WRITE;
          end
        end
        S_WRITE: begin
          if (res_ff.ovf) begin
            // overflow leaves the stack alone and only traps
            done_ff <= mkDone(1'b1, CC_OVERFLOW, 1'b1, 1'b0, 1'b0, regNum_ff, base_ff); // RQ17
            st_ff   <= S_IDLE;
          end else if (!mem_ff.req) begin
            mem_ff.req   <= 1'b1;
            mem_ff.write <= 1'b1;
            mem_ff.addr  <= xferAddr(base_ff, 1'b1, xferIdx_ff); // RQ14
            mem_ff.wdata <= xferIdx_ff[0] ? res_ff.word[15:0] : res_ff.word[31:16];
          end else if (memAck) begin
            mem_ff.req <= 1'b0;
            xferIdx_ff <= xferIdx_ff + 2'h1;
            if (xferIdx_ff[0]) begin
              st_ff <= S_IDLE;
              if (res_ff.unf) begin
                done_ff <= mkDone(1'b1, CC_UNDERFLOW, 1'b1, 1'b1, 1'b0, regNum_ff, base_ff); // RQ17
              end else begin
                done_ff <= mkDone(1'b1, {res_ff.word[31], res_ff.word == 32'h0, 2'b00},
                                  1'b0, 1'b1, 1'b0, regNum_ff, base_ff); // RQ15 RQ16
              end
            end
          end
        end
      endcase
    end
  end

  // operand capture, arithmetic results and the time-left estimate
  always_ff @(posedge clk) begin
    if (srst) begin
      {base_ff, regNum_ff, opSel_ff, aw_ff, bw_ff, res_ff} <= '0;
      {divQ_ff, divRem_ff, divCnt_ff, remain_ff}          <= '0;
    end else begin
      if (take) begin
        base_ff   <= cmdRegValue;
        regNum_ff <= cmdOpcode[2:0]; // RQ1
        opSel_ff  <= cmdOpcode[4:3];
        remain_ff <= 16'(6 * MEM_CYCLES_EST + ((cmdOpcode[4:3] == OP_DIV) ? DIV_STEPS + 3 : 3));
      end else if (remain_ff != 16'h0) begin
        remain_ff <= remain_ff - 16'h1;
      end
      if (st_ff == S_READ && mem_ff.req && memAck) begin
        unique case (xferIdx_ff)
          2'h0: bw_ff[31:16] <= memRdata;
          2'h1: bw_ff[15:0]  <= memRdata;
          2'h2: aw_ff[31:16] <= memRdata;
          2'h3: aw_ff[15:0]  <= memRdata;
        endcase
      end
      if (st_ff == S_CALC) begin
        res_ff    <= resCalc;
        divQ_ff   <= 50'h0;
        divRem_ff <= {2'b00, mant(aw_ff)};
        divCnt_ff <= 6'h0;
      end
      if (st_ff == S_DIV) begin
        divQ_ff   <= nxt_divQ;
        divRem_ff <= nxt_divRem;
        divCnt_ff <= divCnt_ff + 6'h1;
        res_ff    <= resDiv;
      end
    end
  end

  // status seen by software
  always_ff @(posedge clk) begin
    if (srst) begin
      {lastCc_ff, lastTrap_ff, lastAbort_ff, lastResult_ff, wroteOp_ff} <= '0;
    end else begin
      if (take) begin
        wroteOp_ff <= 1'b0;
      end else if (mem_ff.req && mem_ff.write && memAck) begin
        wroteOp_ff <= 1'b1;
      end
      if (done_ff.valid && done_ff.ccWrite) begin
        lastCc_ff   <= {done_ff.n, done_ff.z, done_ff.v, done_ff.c};
        lastTrap_ff <= done_ff.trap;
      end
      if (done_ff.valid) begin
        lastAbort_ff <= done_ff.restart;
      end
      if (done_ff.valid && done_ff.regWrite) begin
        lastResult_ff <= res_ff.word;
      end
    end
  end

  // register slave: one write and one read in flight at most
  logic [AXI_AW-1:0] awAddr_ff;
  logic [31:0]       wData_ff;
  logic [3:0]        wStrb_ff;
  logic              awHave_ff, wHave_ff;

  always_ff @(posedge clk) begin
    if (srst) begin
      {awAddr_ff, wData_ff, wStrb_ff, awHave_ff, wHave_ff} <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      ctrlEnable_ff <= CTRL_ENABLE_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr_ff     <= s_axi_awaddr;
        awHave_ff     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData_ff     <= s_axi_wdata;
        wStrb_ff     <= s_axi_wstrb;
        wHave_ff     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (awHave_ff && wHave_ff && !s_axi_bvalid) begin
        awHave_ff    <= 1'b0;
        wHave_ff     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= RESP_OKAY;
        if (8'(awAddr_ff) == REG_CTRL) begin
          if (wStrb_ff[0]) begin
            ctrlEnable_ff <= wData_ff[0];
          end
        end else if (8'(awAddr_ff) != REG_STATUS && 8'(awAddr_ff) != REG_RESULT) begin
          s_axi_bresp <= RESP_SLVERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= RESP_OKAY;
      if (8'(s_axi_araddr) == REG_CTRL) begin
        s_axi_rdata <= {31'h0, ctrlEnable_ff};
      end else if (8'(s_axi_araddr) == REG_STATUS) begin
        s_axi_rdata <= {25'h0, lastAbort_ff, lastTrap_ff, lastCc_ff, st_ff != S_IDLE};
      end else if (8'(s_axi_araddr) == REG_RESULT) begin
        s_axi_rdata <= lastResult_ff;
      end else begin
        s_axi_rdata <= 32'h0;
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  assign cmdReady = cmdReady_ff;
  assign memOut   = mem_ff;
  assign doneOut  = done_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence sTake;
    take && cmdOpcode[15:5] == OPC_FLOAT;
  endsequence
  sequence sAbort;
    abortNow && (st_ff == S_READ || st_ff == S_CALC || st_ff == S_DIV);
  endsequence

  chk_first_read: assert property (sTake ##1 !bus_priority_request |=> mem_ff.req && !mem_ff.write // RQ13
    && mem_ff.addr == $past(cmdRegValue, 2) + OFF_B_HI) else $error("first read not at B high");
  chk_a_high_slot: assert property (st_ff == S_READ && mem_ff.req && memAck && xferIdx_ff == 2'h2 // RQ13
    |=> aw_ff[31:16] == $past(memRdata)) else $error("A high word misplaced");
  chk_result_place: assert property (mem_ff.req && mem_ff.write |-> mem_ff.addr == base_ff // RQ14
    + (xferIdx_ff[0] ? OFF_A_LO : OFF_A_HI)) else $error("result word at wrong address");
  chk_reg_point: assert property (done_ff.valid && done_ff.regWrite |-> done_ff.regValue // RQ15
    == base_ff + OFF_A_HI && !done_ff.restart) else $error("register not advanced to base plus 4");
  chk_ok_flags: assert property (done_ff.valid && done_ff.ccWrite && !done_ff.trap |-> !done_ff.v // RQ16
    && !done_ff.c && done_ff.z == (res_ff.word == 32'h0) && done_ff.n == res_ff.word[31]) else $error("bad flags");
  chk_trap_code: assert property (done_ff.valid && done_ff.trap |-> done_ff.v && !done_ff.z // RQ17 RQ18
    && (!done_ff.c || done_ff.n) && done_ff.vector == TRAP_VECTOR) else $error("bad trap code");
  chk_div_zero_quiet: assert property (done_ff.valid && done_ff.c |-> !wroteOp_ff // RQ5
    && !done_ff.regWrite) else $error("divide by zero touched the stack");
  chk_clean_zero: assert property (mem_ff.req && mem_ff.write && res_ff.word[30:23] == 8'h00 // RQ12
    |-> mem_ff.wdata == 16'h0000) else $error("zero result not clean");
  chk_zero_operand: assert property (st_ff == S_CALC && opSel_ff == OP_MUL && aw_ff[30:23] == 8'h00 // RQ11
    |=> res_ff.word == 32'h0) else $error("zero operand gave nonzero product");
  chk_mul_sign: assert property (st_ff == S_CALC && opSel_ff == OP_MUL |=> res_ff.word == 32'h0 // RQ3 RQ6
    || res_ff.word[31] == ($past(aw_ff[31]) ^ $past(bw_ff[31]))) else $error("product sign wrong");
  chk_abort_window: assert property (sAbort |=> done_ff.valid && done_ff.restart // RQ19 RQ20
    && !done_ff.regWrite && st_ff == S_IDLE) else $error("abort not taken");
endmodule

// *** hw/sofu_pkg.sv ***
// shared constants and carrier types for the stack operand float unit
package sofu_pkg;
  localparam int CLK_PERIOD_NS    = 25;
  localparam int ABORT_WINDOW_NS  = 8000;
  localparam int ABORT_WINDOW_CYC = ABORT_WINDOW_NS / CLK_PERIOD_NS;
  localparam int DIV_STEPS        = 50;

  localparam logic [10:0] OPC_FLOAT = 11'h3d0;
  localparam logic [1:0]  OP_ADD    = 2'h0;
  localparam logic [1:0]  OP_SUB    = 2'h1;
  localparam logic [1:0]  OP_MUL    = 2'h2;
  localparam logic [1:0]  OP_DIV    = 2'h3;

  localparam logic [15:0] OFF_B_HI    = 16'h0000;
  localparam logic [15:0] OFF_B_LO    = 16'h0002;
  localparam logic [15:0] OFF_A_HI    = 16'h0004;
  localparam logic [15:0] OFF_A_LO    = 16'h0006;
  localparam logic [15:0] TRAP_VECTOR = 16'h00a4;
  localparam logic [7:0]  EXP_BIAS    = 8'h80;

  localparam logic [3:0] CC_OVERFLOW  = 4'h2;
  localparam logic [3:0] CC_UNDERFLOW = 4'ha;
  localparam logic [3:0] CC_DIVZERO   = 4'hb;

  localparam logic [7:0] REG_CTRL        = 8'h00;
  localparam logic [7:0] REG_STATUS      = 8'h04;
  localparam logic [7:0] REG_RESULT      = 8'h08;
  localparam logic       CTRL_ENABLE_RST = 1'b1;
  localparam logic [1:0] RESP_OKAY       = 2'h0;
  localparam logic [1:0] RESP_SLVERR     = 2'h2;

  typedef enum logic [4:0] {
    S_IDLE  = 5'h01,
    S_READ  = 5'h02,
    S_CALC  = 5'h04,
    S_DIV   = 5'h08,
    S_WRITE = 5'h10
  } sofu_state_t;

  typedef struct packed {
    logic        req;
    logic        write;
    logic [15:0] addr;
    logic [15:0] wdata;
  } sofu_mem_t;

  typedef struct packed {
    logic        valid;
    logic        ccWrite;
    logic        n;
    logic        z;
    logic        v;
    logic        c;
    logic        trap;
    logic [15:0] vector;
    logic        regWrite;
    logic [2:0]  regNum;
    logic [15:0] regValue;
    logic        restart;
  } sofu_done_t;

  typedef struct packed {
    logic [31:0] word;
    logic        ovf;
    logic        unf;
  } sofu_res_t;
endpackage

// *** bench/sofu_host_mem.sv ***
// host core memory model serving the unit's operand and result transfers
`timescale 1ns/100ps
module sofu_host_mem
  import sofu_pkg::*;
(
  // clock and reset
  input  wire logic          clk,
  input  wire logic          srst,
  // answer delay in cycles
  input  wire logic [3:0]    waitCycles,
  // transfer port
  input  wire sofu_pkg::sofu_mem_t memOut,
  output logic               memAck,
  output logic [15:0]        memRdata
);
  logic [15:0] mem [0:255];
  logic [3:0]  waitCnt_ff;
  // plain always so the bench may preload words directly
  always @(posedge clk) begin
    memAck <= 1'b0;
    memRdata <= ~memRdata; // read data is not held outside the ack cycle
    if (srst) begin
      waitCnt_ff <= 4'h0;
      memRdata <= 16'h0000;
    end else if (memOut.req && !memAck) begin
      if (waitCnt_ff != waitCycles)
        waitCnt_ff <= waitCnt_ff + 4'h1;
      else begin
        waitCnt_ff <= 4'h0;
        memAck <= 1'b1;
        if (memOut.write)
          mem[memOut.addr[8:1]] <= memOut.wdata;
        else
          memRdata <= mem[memOut.addr[8:1]];
      end
    end
  end
endmodule

// *** bench/test_stack_operand_float_unit.sv ***
// self-checking bench for the stack operand float unit
`timescale 1ns/100ps
module test_stack_operand_float_unit;
  import sofu_pkg::*;
  logic        clk, srst, cmdValid, cmdReady, bus_priority_request, memAck;
  logic [15:0] cmdOpcode, cmdRegValue, memRdata;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, waitCycles;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  sofu_mem_t   memOut;
  sofu_done_t  doneOut;
  int          mismatches, check_count;
  // large transfer estimate so that an early bus request can abandon
  sofu_top #(.MEM_CYCLES_EST(60), .AXI_AW(8)) i_dut (.clk, .srst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cmdValid, .cmdOpcode, .cmdRegValue, .cmdReady,
    .bus_priority_request, .memOut, .memAck, .memRdata, .doneOut);
  sofu_host_mem i_mem (.clk, .srst, .waitCycles, .memOut, .memAck, .memRdata);
  task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    logic aw, w, b;
    b = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 40 && !b; n++) begin
      @(negedge clk);
      aw = s_axi_awvalid & s_axi_awready;
      w = s_axi_wvalid & s_axi_wready;
      b = s_axi_bvalid & s_axi_bready;
      resp = s_axi_bresp;
      @(posedge clk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (b) s_axi_bready <= 1'b0;
    end
    if (!b) begin
      check("write answer", 0, 1);
      tally_and_finish();
    end
  endtask
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    logic ar, r;
    r = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 40 && !r; n++) begin
      @(negedge clk);
      ar = s_axi_arvalid & s_axi_arready;
      r = s_axi_rvalid & s_axi_rready;
      d = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge clk);
      if (ar) s_axi_arvalid <= 1'b0;
      if (r) s_axi_rready <= 1'b0;
    end
    @(posedge clk);
    if (!r) begin
      check("read answer", 0, 1);
      tally_and_finish();
    end
  endtask
  // ab is {A, B}; base is fixed at 16'h0040 through pointer register 5
  task automatic run_op(input logic [1:0] op, input logic [63:0] ab, input logic [31:0] expRes,
                        input logic [3:0] expCc, input logic expTrap, input logic expW, input logic brq);
    logic       got, took;
    sofu_done_t d;
    got = 1'b0;
    {i_mem.mem[8'h22], i_mem.mem[8'h23], i_mem.mem[8'h20], i_mem.mem[8'h21]} = ab;
    cmdOpcode <= {OPC_FLOAT, op, 3'h5};
    cmdRegValue <= 16'h0040;
    cmdValid <= 1'b1;
    bus_priority_request <= brq;
    for (int n = 0; n < 400 && !got; n++) begin
      @(negedge clk);
      took = cmdValid & cmdReady;
      got = doneOut.valid;
      d = doneOut;
      @(posedge clk);
      if (took) cmdValid <= 1'b0;
    end
    bus_priority_request <= 1'b0;
    @(posedge clk);
    if (!got) begin
      check("done", 0, 1);
      tally_and_finish();
    end
    check("restart", d.restart, brq);
    check("stack B", {i_mem.mem[8'h20], i_mem.mem[8'h21]}, ab[31:0]);
    check("stack A", {i_mem.mem[8'h22], i_mem.mem[8'h23]}, expRes);
    check("reg write", d.regWrite, expW);
    if (expW) check("reg value", {d.regNum, d.regValue}, {3'h5, 16'h0044});
    if (!brq) check("flags", {d.ccWrite, d.n, d.z, d.v, d.c}, {1'b1, expCc});
    if (!brq) check("trap", {d.trap, d.trap ? d.vector : 16'h00a4}, {expTrap, 16'h00a4});
  endtask
  task automatic test_regs;
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(REG_CTRL, d, r);
    check("ctrl reset", {r, d}, {2'h0, 32'h1});
    axi_read(8'h0c, d, r);
    check("unmapped", {r, d}, {2'h2, 32'h0});
    axi_write(REG_CTRL, 32'h0, r);
    repeat (3) @(negedge clk);
    check("ready off", cmdReady, 0);
    @(posedge clk);
    axi_write(REG_CTRL, 32'h1, r);
    repeat (3) @(negedge clk);
    check("ready on", {r, cmdReady}, 1);
    @(posedge clk);
    $display("register test done");
  endtask
  task automatic test_add;
    run_op(OP_ADD, {32'h4240_0000, 32'h4240_0000}, 32'h42c0_0000, 4'h0, 0, 1, 0);
    run_op(OP_ADD, {32'h807f_1234, 32'h4240_0000}, 32'h4240_0000, 4'h0, 0, 1, 0);
    $display("add test done");
  endtask
  task automatic test_sub;
    run_op(OP_SUB, {32'h4240_0000, 32'h4240_0000}, 32'h0000_0000, 4'h4, 0, 1, 0);
    run_op(OP_SUB, {32'h4240_0000, 32'h42c0_0000}, 32'hc240_0000, 4'h8, 0, 1, 0);
    $display("subtract test done");
  endtask
  task automatic test_mul;
    waitCycles <= 4'h3; // slow host answers
    run_op(OP_MUL, {32'hc240_0000, 32'h4100_0000}, 32'hc2c0_0000, 4'h8, 0, 1, 0);
    run_op(OP_MUL, {32'h7fc0_0000, 32'h7fc0_0000}, 32'h7fc0_0000, 4'h2, 1, 0, 0);
    run_op(OP_MUL, {32'h0080_0000, 32'h0080_0000}, 32'h0000_0000, 4'ha, 1, 1, 0);
    run_op(OP_MUL, {32'h807f_1234, 32'h4240_0000}, 32'h0000_0000, 4'h4, 0, 1, 0);
    waitCycles <= 4'h0;
    $display("multiply test done");
  endtask
  task automatic test_div;
    logic [31:0] d;
    logic [1:0]  r;
    run_op(OP_DIV, {32'h4080_0000, 32'h4140_0000}, 32'h3faa_aaab, 4'h0, 0, 1, 0);
    run_op(OP_DIV, {32'h4080_0000, 32'h0000_0000}, 32'h4080_0000, 4'hb, 1, 0, 0);
    axi_read(REG_STATUS, d, r);
    check("status", {r, d}, {2'h0, 32'h36});
    axi_read(REG_RESULT, d, r);
    check("result", {r, d}, {2'h0, 32'h3faa_aaab});
    $display("divide test done");
  endtask
  task automatic test_abort;
    run_op(OP_ADD, {32'h4240_0000, 32'h4240_0000}, 32'h4240_0000, 4'h0, 0, 0, 1);
    $display("abort test done");
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    {srst, s_axi_wstrb} = 5'h1f;
    {cmdValid, bus_priority_request, cmdOpcode, cmdRegValue, waitCycles} = '0;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    mismatches = 0;
    check_count = 0;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    test_regs();
    test_add();
    test_sub();
    test_mul();
    test_div();
    test_abort();
    tally_and_finish();
  end
endmodule
